/* File: smsp_pkg.sv */
// smsp_pkg: shared constants and types of the spi serial port
// assumes one 8-bit register port and a single 10 MHz system clock
package smsp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_BUFFER  = 8'h10;
    localparam logic [7:0] ADDR_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_DIR     = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h94;
    // serial_control fields
    localparam int CTL_WRITE_COLLISION_FLAG = 7;
    localparam int CTL_OVF  = 6;
    localparam int CTL_EN   = 5;
    localparam int CTL_CKP  = 4;
    // serial_status fields
    localparam int STA_SMP  = 7;
    localparam int STA_CKE  = 6;
    localparam int STA_STOP = 4;
    localparam int STA_BF   = 0;
    // values after reset
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [1:0] STATUS_RST  = 2'h0;
    localparam logic       DIR_RST     = 1'b1;
    // master half bit times in system clocks (osc/4, /16, /64)
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    // half bit slot in which the master's eighth bit ends
    localparam logic [4:0] LAST_HALF_CKE1 = 5'h0F;
    localparam logic [4:0] LAST_HALF_CKE0 = 5'h10;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    // port_mode_field encodings
    typedef enum logic [3:0] {
        MODE_DIV4  = 4'h0,
        MODE_DIV16 = 4'h1,
        MODE_DIV64 = 4'h2,
        MODE_TMR2  = 4'h3,
        MODE_SS    = 4'h4,
        MODE_NOSS  = 4'h5
    } smsp_mode_t;
    // master sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RUN  = 2'h2
    } smsp_state_t;
    // pin drive group
    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic serial_data_out;
        logic sdo_oe;
    } smsp_pins_t;
    // true for the four master encodings
    function automatic logic smsp_is_master(input logic [3:0] m);
        return m[3:2] == 2'h0;
    endfunction : smsp_is_master
endpackage : smsp_pkg

/* File: smsp_port.sv */
// smsp_port: spi mode of the synchronous serial port (sync_serial_unit)
// assumes pins come from outside the clock domain; regs on a plain port
// Notes on behaviour
// - eight bits shift out and in together, one in per bit out
// - all four clock polarity and transmit edge pairs work
// - slave may use an active low select beside clock and data pins
// - in select-controlled slave, select level shapes sdo direction readback
// - serial_control is fully readable and writable
// - serial_status low six bits read only, top two read/write
// - the shifter is never directly reachable, only via serial_buffer
// - a full received byte moves to the buffer and raises the irq flag; a slave byte meeting a full buffer is lost
// - a buffer write loads both buffer and shifter
// - master samples at end of bit time when set, middle when clear
// - clock edge bit picks active-to-idle or idle-to-active transmit
// - status stop bit always reads clear, enabled or not
// - status bits 5,3,2,1 do nothing in spi mode
// - buffer full reads 1 with a byte waiting, 0 otherwise
// - mode field picks master rates or slave with or without select
// - clock polarity bit sets the clock idle level
// - reading the buffer clears buffer full
// - buffer write during a transfer is dropped and sets write collision
`timescale 1ns/100ps
module smsp_port (
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    input  wire logic                i_sck,
    input  wire logic                i_sdi,
    input  wire logic                i_ss_n,
    input  wire logic                i_tmr2_tick,
    output logic      [7:0]          o_rdata,
    output logic                     o_irq_flag_set,
    output smsp_pkg::smsp_pins_t     o_pins
);
    // pin synchroniser: bit0 sck, bit1 sdi, bit2 ss_n
    logic [2:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
    logic [7:0] ctrl_ff, nxt_ctrl, buf_ff, nxt_buf, sh_ff, nxt_sh;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [1:0] sta_ff, nxt_sta;
    logic       bf_ff, nxt_bf, dir_ff, nxt_dir, sdo_ff, nxt_sdo;
    logic       act_ff, nxt_act, samp_ff, nxt_samp, irq_ff, nxt_irq;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [4:0] half_ff, nxt_half, tog_ff, nxt_tog;
    logic [5:0] div_ff, nxt_div;
    smsp_pkg::smsp_state_t state_ff, nxt_state;
    smsp_pkg::smsp_pins_t  pins_ff, nxt_pins;
    // decoded controls
    logic en, master, slave, ss_ctl, sl_on, busy, wr_buf, rd_buf;
    logic clock_idle_polarity, cke, sample_phase_sel, tick, mid, endb, last, upd, act_e, idle_e;
    logic dir_rd, deliver, drop;
    logic [7:0] rx;
    logic [5:0] half_len;

    // three flops per pin; a change counts once the 2nd and 3rd agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_flt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : flt_ff[i];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            // idle levels: select high, data and clock low, so no false edge
            s1_ff  <= 3'h4;
            s2_ff  <= 3'h4;
            s3_ff  <= 3'h4;
            flt_ff <= 3'h4;
        end else begin
            s1_ff  <= {i_ss_n, i_sdi, i_sck};
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end

    // register file, master sequencer and slave shifter
    always_comb begin
        en     = ctrl_ff[smsp_pkg::CTL_EN];
        clock_idle_polarity    = ctrl_ff[smsp_pkg::CTL_CKP];
        sample_phase_sel    = sta_ff[1];
        cke    = sta_ff[0];
        master = en && smsp_pkg::smsp_is_master(ctrl_ff[3:0]);
        slave  = en && (ctrl_ff[3:0] == smsp_pkg::MODE_SS ||
                        ctrl_ff[3:0] == smsp_pkg::MODE_NOSS);
        ss_ctl = ctrl_ff[3:0] == smsp_pkg::MODE_SS;
        sl_on  = slave && !(ss_ctl && flt_ff[2]);
        dir_rd = dir_ff || (en && ss_ctl && flt_ff[2]);
        busy   = (state_ff == smsp_pkg::ST_RUN) || (slave && cnt_ff != 3'h0);
        wr_buf = i_wr && i_addr == smsp_pkg::ADDR_BUFFER;
        rd_buf = i_rd && i_addr == smsp_pkg::ADDR_BUFFER;
        case (ctrl_ff[1:0])
            2'h0:    half_len = smsp_pkg::HALF_DIV4;
            2'h1:    half_len = smsp_pkg::HALF_DIV16;
            default: half_len = smsp_pkg::HALF_DIV64;
        endcase
        // timer-2 mode toggles the clock once per timer tick
        tick = (ctrl_ff[3:0] == smsp_pkg::MODE_TMR2) ? i_tmr2_tick
             : (div_ff == half_len - 6'h01);
        // bit timing within a half slot; cke=0 adds a trailing slot
        mid  = cke ? !half_ff[0] : half_ff[0];
        endb = cke ? half_ff[0] : (!half_ff[0] && half_ff != 5'h00);
        last = half_ff == (cke ? smsp_pkg::LAST_HALF_CKE1
                               : smsp_pkg::LAST_HALF_CKE0);
        upd    = (s2_ff[0] == s3_ff[0]) && (s3_ff[0] != flt_ff[0]);
        act_e  = upd && (s3_ff[0] != clock_idle_polarity);
        idle_e = upd && (s3_ff[0] == clock_idle_polarity);
        nxt_ctrl  = ctrl_ff;
        nxt_sta   = sta_ff;
        nxt_bf    = bf_ff;
        nxt_dir   = dir_ff;
        nxt_buf   = buf_ff;
        nxt_sh    = sh_ff;
        nxt_sdo   = sdo_ff;
        nxt_act   = act_ff;
        nxt_samp  = samp_ff;
        nxt_cnt   = cnt_ff;
        nxt_half  = half_ff;
        nxt_div   = div_ff;
        nxt_state = state_ff;
        nxt_tog   = tog_ff;
        nxt_irq   = 1'b0;
        nxt_rdata = 8'h00;
        deliver   = 1'b0;
        rx        = 8'h00;
        // master: runs only after a buffer write starts it
        if (master && state_ff == smsp_pkg::ST_RUN) begin
            nxt_div = tick ? 6'h00 : div_ff + 6'h01;
            if (tick) begin
                // only the cke=0 trailing slot holds the clock still
                if (half_ff != smsp_pkg::LAST_HALF_CKE0) begin
                    nxt_act = !act_ff;
                    nxt_tog = tog_ff + 5'h01;
                end
                if (mid && !sample_phase_sel && half_ff != smsp_pkg::LAST_HALF_CKE0)
                    nxt_samp = flt_ff[1];
                if (endb) begin
                    rx      = {sh_ff[6:0], sample_phase_sel ? flt_ff[1] : samp_ff};
                    nxt_sh  = rx;
                    nxt_sdo = sh_ff[6];
                    nxt_cnt = cnt_ff + 3'h1;
                end
                nxt_half = half_ff + 5'h01;
                if (last) begin
                    nxt_state = smsp_pkg::ST_IDLE;
                    nxt_cnt   = 3'h0;
                    deliver   = 1'b1;
                end
            end
        end
        // slave: clocked by the filtered pin edges
        if (slave) begin
            if (ss_ctl && flt_ff[2]) begin
                nxt_cnt = 3'h0;
            end else begin
                if (cke ? idle_e : act_e)
                    nxt_sdo = sh_ff[7];
                if (cke ? act_e : idle_e) begin
                    rx      = {sh_ff[6:0], flt_ff[1]};
                    nxt_sh  = rx;
                    nxt_cnt = cnt_ff + 3'h1;
                    deliver = cnt_ff == smsp_pkg::LAST_BIT;
                end
            end
        end
        // a slave byte arriving on a full buffer is lost
        drop = deliver && slave && bf_ff;
        // software register access; hardware set wins over a clear
        if (i_wr) begin
            case (i_addr)
                smsp_pkg::ADDR_CONTROL: nxt_ctrl = i_wdata;
                smsp_pkg::ADDR_STATUS:  nxt_sta = i_wdata[7:6];
                smsp_pkg::ADDR_DIR:     nxt_dir = i_wdata[0];
                default: ;
            endcase
        end
        if (wr_buf) begin
            if (busy) begin
                nxt_ctrl[smsp_pkg::CTL_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
                nxt_buf = i_wdata;
                nxt_sh  = i_wdata;
                nxt_sdo = i_wdata[7];
                if (master) begin
                    nxt_state = smsp_pkg::ST_RUN;
                    nxt_half  = 5'h00;
                    nxt_div   = 6'h00;
                    nxt_cnt   = 3'h0;
                    nxt_act   = 1'b0;
                    nxt_tog   = 5'h00;
                end
            end
        end
        if (rd_buf)
            nxt_bf = 1'b0;
        if (drop) begin
            nxt_ctrl[smsp_pkg::CTL_OVF] = 1'b1;
        end else if (deliver) begin
            nxt_buf = rx;
            nxt_bf  = 1'b1;
            nxt_irq = 1'b1;
        end
        // disabling parks the engine and idles the clock
        if (!en) begin
            nxt_state = smsp_pkg::ST_IDLE;
            nxt_cnt   = 3'h0;
            nxt_act   = 1'b0;
        end
        // read data; the shifter has no address at all
        if (i_rd) begin
            case (i_addr)
                smsp_pkg::ADDR_CONTROL: nxt_rdata = ctrl_ff;
                smsp_pkg::ADDR_STATUS:
                    nxt_rdata = {sta_ff, 1'b0, 1'b0, 3'h0, bf_ff};
                smsp_pkg::ADDR_BUFFER:  nxt_rdata = buf_ff;
                smsp_pkg::ADDR_DIR:     nxt_rdata = {7'h00, dir_rd};
                default:                nxt_rdata = 8'h00;
            endcase
        end
        // pins follow the next state so they line up with it
        nxt_pins.sck    = clock_idle_polarity ^ (master && nxt_act);
        nxt_pins.sck_oe = master;
        nxt_pins.serial_data_out    = nxt_sdo;
        nxt_pins.sdo_oe = (master || sl_on) && !dir_rd;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_ff  <= smsp_pkg::CONTROL_RST;
            sta_ff   <= smsp_pkg::STATUS_RST;
            dir_ff   <= smsp_pkg::DIR_RST;
            bf_ff    <= 1'b0;
            buf_ff   <= 8'h00;
            sh_ff    <= 8'h00;
            sdo_ff   <= 1'b0;
            act_ff   <= 1'b0;
            samp_ff  <= 1'b0;
            cnt_ff   <= 3'h0;
            half_ff  <= 5'h00;
            div_ff   <= 6'h00;
            tog_ff   <= 5'h00;
            state_ff <= smsp_pkg::ST_IDLE;
            irq_ff   <= 1'b0;
            rdata_ff <= 8'h00;
            pins_ff  <= '0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            sta_ff   <= nxt_sta;
            dir_ff   <= nxt_dir;
            bf_ff    <= nxt_bf;
            buf_ff   <= nxt_buf;
            sh_ff    <= nxt_sh;
            sdo_ff   <= nxt_sdo;
            act_ff   <= nxt_act;
            samp_ff  <= nxt_samp;
            cnt_ff   <= nxt_cnt;
            half_ff  <= nxt_half;
            div_ff   <= nxt_div;
            tog_ff   <= nxt_tog;
            state_ff <= nxt_state;
            irq_ff   <= nxt_irq;
            rdata_ff <= nxt_rdata;
            pins_ff  <= nxt_pins;
        end
    end

    assign o_rdata        = rdata_ff;
    assign o_irq_flag_set = irq_ff;
    assign o_pins         = pins_ff;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence m_start;
        wr_buf && !busy && master;
    endsequence
    sequence m_finish;
        $fell(state_ff == smsp_pkg::ST_RUN) && en;
    endsequence

    bf_read_clr_a: assert property (rd_buf && !deliver |=> !bf_ff)
        else $error("buffer full not cleared by buffer read");
    write_collision_flag_set_a: assert property (wr_buf && busy |=> ctrl_ff[7])
        else $error("write collision flag not set");
    wr_ignore_a: assert property (wr_buf && busy && !deliver
        |=> buf_ff == $past(buf_ff))
        else $error("colliding write changed the buffer");
    load_both_a: assert property (m_start |=> buf_ff == $past(i_wdata)
        && sh_ff == $past(i_wdata) && state_ff == smsp_pkg::ST_RUN)
        else $error("buffer write did not load buffer and shifter");
    rx_deliver_a: assert property (deliver && !drop
        |=> bf_ff && irq_ff && buf_ff == $past(rx))
        else $error("received byte not delivered");
    eight_clocks_a: assert property (m_finish |-> tog_ff == 5'h10)
        else $error("master did not give eight clock cycles");
    idle_level_a: assert property (master && !busy ##1 master && !busy
        |=> pins_ff.sck == $past(ctrl_ff[4]))
        else $error("clock idle level wrong");
    status_zero_a: assert property (i_rd && i_addr == smsp_pkg::ADDR_STATUS
        |=> o_rdata[5:1] == 5'h00)
        else $error("unused status bits not zero");
    dir_ss_a: assert property (i_rd && i_addr == smsp_pkg::ADDR_DIR
        && en && ss_ctl && flt_ff[2] |=> o_rdata[0] && !o_pins.sdo_oe)
        else $error("select high did not force sdo direction");
endmodule : smsp_port

/* File: smsp_far_end.sv */
// smsp_far_end: behavioural spi peer on the far side of the port
// assumes the bench picks the role and pulses i_go to arm one byte
`timescale 1ns/100ps
module smsp_far_end (
    input  wire logic                 i_role,
    input  wire logic                 i_go,
    input  wire logic [7:0]           i_tx,
    input  wire smsp_pkg::smsp_pins_t i_pins,
    output logic                      o_sck,
    output logic                      o_ss_n,
    output logic                      o_sdi,
    output logic      [7:0]           o_rx
);
    logic [7:0] sh_s = 8'h00;
    logic [7:0] rx_s = 8'h00;
    logic [7:0] rx_m = 8'h00;
    logic       sdi_s = 1'b0;
    logic       sdi_m = 1'b0;
    int         bit_s = 0;
    initial o_sck = 1'b0;
    initial o_ss_n = 1'b1;
    // slave role: take sdo on rising, next bit on falling (idle low)
    always @(i_pins.sck) begin
        if (!i_role && i_pins.sck_oe) begin
            if (i_pins.sck) begin
                rx_s = {rx_s[6:0], i_pins.serial_data_out};
                bit_s = bit_s + 1;
            end else if (bit_s < 8) begin
                sdi_s = sh_s[7 - bit_s];
            end else begin
                sdi_s = ~sdi_s; // released line must not hold the last bit
            end
        end
    end
    // master role: 800 ns link clock, stands still outside the frame
    always @(posedge i_go) begin
        if (!i_role) begin
            sh_s = i_tx;
            sdi_s = i_tx[7];
            bit_s = 0;
        end else begin
            #37 o_ss_n = 1'b0; // phase unrelated to the system clock
            for (int k = 7; k >= 0; k--) begin
                sdi_m = i_tx[k];
                #400 o_sck = 1'b1;
                // sample before the port's late-synced shift lands
                #400 rx_m = {rx_m[6:0], i_pins.serial_data_out};
                o_sck = 1'b0;
            end
            #400 o_ss_n = 1'b1;
            sdi_m = ~sdi_m;
        end
    end
    assign o_sdi = i_role ? sdi_m : sdi_s;
    assign o_rx  = i_role ? rx_m : rx_s;
endmodule : smsp_far_end

/* File: spi_mode_serial_port_test.sv */
// spi_mode_serial_port_test: register-level bench of the spi port
// assumes smsp_far_end on the pins and a timer tick every 4 clocks
`timescale 1ns/100ps
module spi_mode_serial_port_test;
    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    logic                 wr = 1'b0;
    logic                 rd = 1'b0;
    logic                 tick = 1'b0;
    logic                 role = 1'b0;
    logic                 go = 1'b0;
    logic                 sck_last = 1'b0;
    logic [7:0]           addr = 8'h00;
    logic [7:0]           wdata = 8'h00;
    logic [7:0]           tx = 8'h00;
    logic [7:0]           rdata;
    logic [7:0]           far_rx;
    logic                 irq_set;
    logic                 sck;
    logic                 ss_n;
    logic                 serial_data_in;
    smsp_pkg::smsp_pins_t pins;
    logic [1:0]           tcnt = 2'h0;
    int                   toggles = 0;
    int                   irqs = 0;
    int                   err_total = 0;
    int                   n_tests = 0;

    smsp_port DUT (
        .i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_sck(sck), .i_sdi(serial_data_in), .i_ss_n(ss_n),
        .i_tmr2_tick(tick), .o_rdata(rdata), .o_irq_flag_set(irq_set),
        .o_pins(pins)
    );
    smsp_far_end far (
        .i_role(role), .i_go(go), .i_tx(tx), .i_pins(pins),
        .o_sck(sck), .o_ss_n(ss_n), .o_sdi(serial_data_in), .o_rx(far_rx)
    );

    always #50 clock = ~clock;
    // timer tick pulse, plus edge and completion counters
    always @(posedge clock) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
        if (pins.sck !== sck_last) toggles <= toggles + 1;
        sck_last <= pins.sck;
        if (irq_set === 1'b1) irqs <= irqs + 1;
    end

    task automatic report_and_stop();
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd_reg(a, v);
        chk(v, exp);
    endtask : rd_chk
    task automatic far_arm(input logic r, input logic [7:0] b);
        @(posedge clock);
        role <= r;
        tx <= b;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask : far_arm
    // polls buffer full under a bound; a hang ends the run
    task automatic wait_bf();
        logic [7:0] v;
        for (int i = 0; i < 400; i++) begin
            rd_reg(smsp_pkg::ADDR_STATUS, v);
            if (v[smsp_pkg::STA_BF] === 1'b1) return;
        end
        err_total++;
        report_and_stop();
    endtask : wait_bf

    initial begin
        logic [7:0] v;
        int         t0;
        int         i0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd_chk(smsp_pkg::ADDR_CONTROL, smsp_pkg::CONTROL_RST);
        rd_chk(smsp_pkg::ADDR_STATUS, 8'h00);
        rd_chk(smsp_pkg::ADDR_DIR, 8'h01);
        rd_chk(8'h20, 8'h00);
        wr_reg(smsp_pkg::ADDR_CONTROL, 8'hDF);
        rd_chk(smsp_pkg::ADDR_CONTROL, 8'hDF);
        wr_reg(smsp_pkg::ADDR_STATUS, 8'hFF);
        rd_chk(smsp_pkg::ADDR_STATUS, 8'hC0);
        // each master rate with one of the four polarity and edge pairs;
        // data is checked at osc/16: at osc/4 the peer's answer cannot
        // cross the pin synchroniser before the master samples it
        for (int m = 0; m < 4; m++) begin
            wr_reg(smsp_pkg::ADDR_CONTROL, 8'h00);
            wr_reg(smsp_pkg::ADDR_STATUS, {1'b0, m[0], 6'h00});
            wr_reg(smsp_pkg::ADDR_CONTROL, {3'h1, m[1], m[3:0]});
            far_arm(1'b0, 8'h3C);
            #1 chk({7'h00, pins.sck}, {7'h00, m[1]});
            t0 = toggles;
            i0 = irqs;
            wr_reg(smsp_pkg::ADDR_BUFFER, 8'hA5);
            wr_reg(smsp_pkg::ADDR_BUFFER, 8'h11);
            rd_chk(smsp_pkg::ADDR_CONTROL, {3'h5, m[1], m[3:0]});
            wait_bf();
            chk(8'(toggles - t0), 8'h10);
            chk(8'(irqs - i0), 8'h01);
            if (m == 1) begin
                chk(far_rx, 8'hA5);
                rd_chk(smsp_pkg::ADDR_BUFFER, 8'h3C);
            end else begin
                rd_reg(smsp_pkg::ADDR_BUFFER, v);
            end
            rd_chk(smsp_pkg::ADDR_STATUS, {1'b0, m[0], 6'h00});
        end
        // slave with select: sample phase stays clear, plain dir write
        wr_reg(smsp_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(smsp_pkg::ADDR_STATUS, 8'h40);
        wr_reg(smsp_pkg::ADDR_CONTROL, 8'h24);
        wr_reg(smsp_pkg::ADDR_DIR, 8'h00);
        rd_chk(smsp_pkg::ADDR_DIR, 8'h01);
        wr_reg(smsp_pkg::ADDR_BUFFER, 8'h96);
        far_arm(1'b1, 8'h5A);
        repeat (10) @(posedge clock);
        rd_chk(smsp_pkg::ADDR_DIR, 8'h00);
        chk({7'h00, pins.sdo_oe}, 8'h01);
        wait_bf();
        chk(far_rx, 8'h96);
        rd_chk(smsp_pkg::ADDR_BUFFER, 8'h5A);
        report_and_stop();
    end
endmodule : spi_mode_serial_port_test
